// file: verilog/ubfc_top.sv
// UART baud, frame format and enable control with AHB-Lite register access
`timescale 1ns/1ps
`include "ubfc_params.svh"
module ubfc_top (
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        rx_in,
    output logic             tx_out,
    output logic             tx_oe_out
);
    import ubfc_pkg::*;
    ubfc_ahb_req_t  req_reg;
    ubfc_frame_t    frame_reg;
    ubfc_tx_state_t tx_st_reg;
    ubfc_rx_state_t rx_st_reg;
    logic           uart_en_reg, tx_en_reg, rx_en_reg, brk_reg, hs_reg, tx8_reg;
    logic     [7:0] div_reg, tx_hold_reg;
    logic           tx_full_reg, tx_idle_reg, tx_line_reg, own_reg;
    logic     [8:0] tx_shift_reg, rx_shift_reg, rx_buf_reg;
    logic     [3:0] tx_sub_reg, tx_cnt_reg, rx_sub_reg, rx_cnt_reg;
    logic           rx_s1_reg, rx_s2_reg, noise_acc_reg;
    logic     [2:0] vote_reg;
    logic           avail_reg, overrun_error_reg, framing_error_reg, parity_error_reg, nf_reg;
    logic           addr_phase, wr_c1, wr_c2, wr_div, wr_data, rd_data, tick;
    logic           tx_end, rx_end, maj, noisy, rx_done, rx_keep, rx_parity_error, rx_msb;
    logic     [3:0] last_bit;
    logic     [8:0] rx_word;
    logic     [7:0] rd_mux;

    // Top bit carries parity when enabled; even parity makes the ones count even
    function automatic logic [8:0] ubfc_pack(input logic [8:0] w, input ubfc_frame_t f);
        logic [8:0] m;
        logic       p;
        m = f.nine_bit_select ? w : {1'b0, w[7:0]};
        p = (f.nine_bit_select ? ^m[7:0] : ^m[6:0]) ^ f.parity_type;
        if (f.parity_enable && f.nine_bit_select) begin
            m[8] = p;
        end else if (f.parity_enable) begin
            m[7] = p;
        end
        return m;
    endfunction

    ubfc_baud_timer u_baud (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .cfg_in     (ubfc_baud_cfg_t'{baud_high_speed: hs_reg, baud_divisor: div_reg}),
        .tick_out   (tick)
    );

    // Bus address phase capture; the slave never inserts wait states
    assign addr_phase = hsel_in && htrans_in[1] && hready_in;
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            req_reg <= '0;
        end else if (hready_in) begin
            req_reg <= '{valid: addr_phase, write: hwrite_in, addr: haddr_in[7:0]};
        end
    end

    assign wr_c1   = req_reg.valid && req_reg.write && (req_reg.addr == `UBFC_OFS_CTRL1);
    assign wr_c2   = req_reg.valid && req_reg.write && (req_reg.addr == `UBFC_OFS_CTRL2);
    assign wr_div  = req_reg.valid && req_reg.write && (req_reg.addr == `UBFC_OFS_DIV);
    assign wr_data = req_reg.valid && req_reg.write && (req_reg.addr == `UBFC_OFS_DATA)
                     && uart_en_reg && !tx_full_reg;
    assign rd_data = addr_phase && !hwrite_in && (haddr_in[7:0] == `UBFC_OFS_DATA);

    // Read data is fetched in the address phase so it stands in the data phase
    always_comb begin
        unique case (haddr_in[7:0])
            `UBFC_OFS_CTRL1:  rd_mux = {uart_en_reg, frame_reg.nine_bit_select,
                                        frame_reg.parity_enable, frame_reg.parity_type,
                                        frame_reg.two_stop_select, brk_reg,
                                        rx_buf_reg[8], tx8_reg};
            `UBFC_OFS_CTRL2:  rd_mux = {tx_en_reg, rx_en_reg, hs_reg,
                                        frame_reg.addr_detect_enable, 4'h0};
            `UBFC_OFS_DIV:    rd_mux = div_reg;
            `UBFC_OFS_STATUS: rd_mux = {parity_error_reg, nf_reg, framing_error_reg, overrun_error_reg, avail_reg,
                                        rx_st_reg == RX_IDLE, !tx_full_reg, tx_idle_reg};
            `UBFC_OFS_DATA:   rd_mux = rx_buf_reg[7:0];
            default:          rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else begin
            hrdata_out    <= (addr_phase && !hwrite_in) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
    end

    // Format, speed and divisor survive a disable untouched
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            uart_en_reg <= 1'b0;
            frame_reg   <= '0;
            tx8_reg     <= 1'b0;
            hs_reg      <= 1'b0;
            div_reg     <= `UBFC_DIV_RST;
        end else begin
            if (wr_c1) begin
                uart_en_reg                 <= hwdata_in[`UBFC_C1_EN];
                frame_reg.nine_bit_select   <= hwdata_in[`UBFC_C1_NINE];
                frame_reg.parity_enable     <= hwdata_in[`UBFC_C1_PEN];
                frame_reg.parity_type       <= hwdata_in[`UBFC_C1_PTYPE];
                frame_reg.two_stop_select   <= hwdata_in[`UBFC_C1_STOP2];
                tx8_reg                     <= hwdata_in[`UBFC_C1_TX8];
            end
            if (wr_c2) begin
                hs_reg                       <= hwdata_in[`UBFC_C2_HS];
                frame_reg.addr_detect_enable <= hwdata_in[`UBFC_C2_ADDR];
            end
            if (wr_div) begin
                div_reg <= hwdata_in[7:0];
            end
        end
    end

    // Enables and break are forced low while the UART is off
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !uart_en_reg) begin
            tx_en_reg <= 1'b0;
            rx_en_reg <= 1'b0;
            brk_reg   <= 1'b0;
        end else begin
            if (wr_c2) begin
                tx_en_reg <= hwdata_in[`UBFC_C2_TX_ENABLE];
                rx_en_reg <= hwdata_in[`UBFC_C2_RX_ENABLE];
            end
            if (wr_c1) begin
                brk_reg <= hwdata_in[`UBFC_C1_BRK];
            end
        end
    end

    // Pin ownership; outside it the pad belongs to the pin mux
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            own_reg <= 1'b0;
        end else begin
            own_reg <= uart_en_reg && tx_en_reg && rx_en_reg;
        end
    end
    assign tx_oe_out = own_reg;
    assign tx_out    = tx_line_reg;

    // Transmit holding buffer and transmitter status flags
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !uart_en_reg) begin
            tx_full_reg <= 1'b0;
            tx_idle_reg <= 1'b1;
            tx_hold_reg <= 8'h00;
        end else begin
            if (wr_data) begin
                tx_full_reg <= 1'b1;
                tx_hold_reg <= hwdata_in[7:0];
            end else if (tx_st_reg == TX_IDLE && tx_full_reg && tx_en_reg) begin
                tx_full_reg <= 1'b0;
            end
            // A frame ending in the same cycle as a data write still marks idle
            if (tx_st_reg == TX_STOP && tx_end && !tx_full_reg) begin
                tx_idle_reg <= 1'b1;
            end else if (wr_data) begin
                tx_idle_reg <= 1'b0;
            end
        end
    end

    assign last_bit = frame_reg.nine_bit_select ? `UBFC_LAST_BIT9 : `UBFC_LAST_BIT8;
    assign tx_end   = tick && (tx_sub_reg == `UBFC_LAST_TICK);
    assign rx_end   = tick && (rx_sub_reg == `UBFC_LAST_TICK);

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || tx_st_reg == TX_IDLE) begin
            tx_sub_reg <= 4'h0;
        end else if (tick) begin
            tx_sub_reg <= 4'(tx_sub_reg + 4'h1);
        end
    end

    // Transmit sequencer; dropping either enable aborts the frame at once
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !uart_en_reg || !tx_en_reg) begin
            tx_st_reg    <= TX_IDLE;
            tx_line_reg  <= 1'b1;
            tx_shift_reg <= 9'h000;
            tx_cnt_reg   <= 4'h0;
        end else begin
            unique case (tx_st_reg)
                TX_IDLE: begin
                    tx_line_reg <= !tx_full_reg;
                    if (tx_full_reg) begin
                        tx_st_reg    <= TX_START;
                        tx_shift_reg <= ubfc_pack({tx8_reg, tx_hold_reg}, frame_reg);
                    end
                end
                TX_START: if (tx_end) begin
                    tx_st_reg    <= TX_DATA;
                    tx_line_reg  <= tx_shift_reg[0];
                    tx_shift_reg <= tx_shift_reg >> 1;
                    tx_cnt_reg   <= 4'h0;
                end
                TX_DATA: if (tx_end) begin
                    if (tx_cnt_reg == last_bit) begin
                        tx_st_reg   <= TX_STOP;
                        tx_line_reg <= 1'b1;
                        tx_cnt_reg  <= 4'h0;
                    end else begin
                        tx_line_reg  <= tx_shift_reg[0];
                        tx_shift_reg <= tx_shift_reg >> 1;
                        tx_cnt_reg   <= 4'(tx_cnt_reg + 4'h1);
                    end
                end
                TX_STOP: if (tx_end) begin
                    if (frame_reg.two_stop_select && tx_cnt_reg == 4'h0) begin
                        tx_cnt_reg <= 4'h1;
                    end else begin
                        tx_st_reg <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // Serial input crosses into the clock domain before use
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
        end else begin
            rx_s1_reg <= rx_in;
            rx_s2_reg <= rx_s1_reg;
        end
    end

    // Three votes around mid bit reject single glitches and flag noise
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || rx_st_reg == RX_IDLE) begin
            rx_sub_reg <= 4'h0;
            vote_reg   <= 3'h7;
        end else if (tick) begin
            rx_sub_reg <= 4'(rx_sub_reg + 4'h1);
            if (rx_sub_reg == `UBFC_VOTE_A) vote_reg[0] <= rx_s2_reg;
            if (rx_sub_reg == `UBFC_VOTE_B) vote_reg[1] <= rx_s2_reg;
            if (rx_sub_reg == `UBFC_VOTE_C) vote_reg[2] <= rx_s2_reg;
        end
    end
    assign maj   = (vote_reg[0] & vote_reg[1]) | (vote_reg[0] & vote_reg[2])
                 | (vote_reg[1] & vote_reg[2]);
    assign noisy = !(&vote_reg) && (|vote_reg);

    // Receive sequencer; listens only while it owns the pins
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !uart_en_reg || !own_reg) begin
            rx_st_reg     <= RX_IDLE;
            rx_shift_reg  <= 9'h000;
            rx_cnt_reg    <= 4'h0;
            noise_acc_reg <= 1'b0;
        end else begin
            unique case (rx_st_reg)
                RX_IDLE: if (!rx_s2_reg) begin
                    rx_st_reg     <= RX_START;
                    noise_acc_reg <= 1'b0;
                end
                RX_START: if (rx_end) begin
                    rx_st_reg  <= maj ? RX_IDLE : RX_DATA;
                    rx_cnt_reg <= 4'h0;
                end
                RX_DATA: if (rx_end) begin
                    rx_shift_reg  <= {maj, rx_shift_reg[8:1]};
                    noise_acc_reg <= noise_acc_reg || noisy;
                    rx_cnt_reg    <= 4'(rx_cnt_reg + 4'h1);
                    if (rx_cnt_reg == last_bit) rx_st_reg <= RX_STOP;
                end
                RX_STOP: if (rx_end) begin
                    rx_st_reg <= RX_IDLE;
                end
            endcase
        end
    end

    assign rx_done = (rx_st_reg == RX_STOP) && rx_end;
    assign rx_word = frame_reg.nine_bit_select ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
    assign rx_msb  = frame_reg.nine_bit_select ? rx_word[8] : rx_word[7];
    assign rx_parity_error = frame_reg.parity_enable && (ubfc_pack(rx_word, frame_reg) != rx_word);
    assign rx_keep = !(frame_reg.addr_detect_enable && !rx_msb);

    // Receive buffer and flags; a new word wins over a clearing read
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !uart_en_reg) begin
            avail_reg  <= 1'b0;
            overrun_error_reg   <= 1'b0;
            framing_error_reg   <= 1'b0;
            parity_error_reg   <= 1'b0;
            nf_reg     <= 1'b0;
            rx_buf_reg <= 9'h000;
        end else if (rx_done && rx_keep && avail_reg && !rd_data) begin
            overrun_error_reg <= 1'b1;
        end else if (rx_done && rx_keep) begin
            avail_reg  <= 1'b1;
            rx_buf_reg <= rx_word;
            framing_error_reg   <= !maj;
            parity_error_reg   <= rx_parity_error;
            nf_reg     <= noise_acc_reg || noisy;
        end else if (rd_data) begin
            avail_reg <= 1'b0;
            overrun_error_reg  <= 1'b0;
            framing_error_reg  <= 1'b0;
            parity_error_reg  <= 1'b0;
            nf_reg    <= 1'b0;
        end
    end

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence en_drop_s;
        uart_en_reg ##1 !uart_en_reg;
    endsequence

    idle_line_high_a: assert property ((tx_st_reg == TX_IDLE) |-> tx_line_reg)
        else $error("serial output low outside a frame");
    disable_flags_a: assert property (en_drop_s |=> (!avail_reg && !overrun_error_reg && !framing_error_reg
        && !parity_error_reg && !nf_reg && tx_idle_reg && !tx_full_reg && !tx_en_reg && !rx_en_reg))
        else $error("flags not reset by disable");
    pin_release_a: assert property (!uart_en_reg |=> ##1 !tx_oe_out)
        else $error("pin still owned after disable");
    abort_frame_a: assert property (en_drop_s |=> (tx_st_reg == TX_IDLE
        && rx_st_reg == RX_IDLE && tx_line_reg))
        else $error("transfer not aborted on disable");
    config_kept_a: assert property ((en_drop_s ##0 (!wr_div && !wr_c2 && !wr_c1)) |=>
        ($stable(div_reg) && $stable(hs_reg) && $stable(frame_reg)))
        else $error("configuration changed by disable");
    stop_count_a: assert property ((tx_st_reg == TX_STOP && tx_end && tx_en_reg
        && uart_en_reg && !frame_reg.two_stop_select && !wr_c1) |=> tx_st_reg == TX_IDLE)
        else $error("single stop not ended after one bit");
    lsb_first_a: assert property ((tx_st_reg == TX_START && tx_end && tx_en_reg
        && uart_en_reg && !wr_c1) |=> tx_line_reg == $past(tx_shift_reg[0]))
        else $error("first data bit is not the lsb");
    addr_drop_a: assert property ((rx_done && frame_reg.addr_detect_enable && !rx_msb
        && !avail_reg && uart_en_reg) |=> !avail_reg)
        else $error("data word kept under address detect");
endmodule

// file: verilog/ubfc_params.svh
// Register map, bit positions and reset values of the UART baud and frame control block
`ifndef UBFC_PARAMS_SVH
`define UBFC_PARAMS_SVH
`define UBFC_OFS_CTRL1   8'h00
`define UBFC_OFS_CTRL2   8'h04
`define UBFC_OFS_DIV     8'h08
`define UBFC_OFS_STATUS  8'h0c
`define UBFC_OFS_DATA    8'h10
`define UBFC_C1_EN       7
`define UBFC_C1_NINE     6
`define UBFC_C1_PEN      5
`define UBFC_C1_PTYPE    4
`define UBFC_C1_STOP2    3
`define UBFC_C1_BRK      2
`define UBFC_C1_TX8      0
`define UBFC_C2_TX_ENABLE     7
`define UBFC_C2_RX_ENABLE     6
`define UBFC_C2_HS       5
`define UBFC_C2_ADDR     4
`define UBFC_DIV_RST     8'h00
`define UBFC_LOW_PRE     2'h3
`define UBFC_LAST_TICK   4'hf
`define UBFC_VOTE_A      4'h7
`define UBFC_VOTE_B      4'h8
`define UBFC_VOTE_C      4'h9
`define UBFC_LAST_BIT8   4'h7
`define UBFC_LAST_BIT9   4'h8
`endif

// file: verilog/ubfc_pkg.sv
// Types shared by the UART baud and frame control block
package ubfc_pkg;
    typedef struct packed {
        logic nine_bit_select;
        logic parity_enable;
        logic parity_type;
        logic two_stop_select;
        logic addr_detect_enable;
    } ubfc_frame_t;
    typedef struct packed {
        logic       baud_high_speed;
        logic [7:0] baud_divisor;
    } ubfc_baud_cfg_t;
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } ubfc_ahb_req_t;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ubfc_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ubfc_rx_state_t;
endpackage

// file: verilog/ubfc_baud_timer.sv
// Free running baud timer giving one 16x oversampling tick per period
`timescale 1ns/1ps
`include "ubfc_params.svh"
module ubfc_baud_timer (
    input  wire logic                     ref_clk_in,
    input  wire logic                     sys_rst_in,
    input  wire ubfc_pkg::ubfc_baud_cfg_t cfg_in,
    output logic                          tick_out
);
    import ubfc_pkg::*;
    logic       [1:0]  pre_reg;
    logic       [7:0]  cnt_reg;
    logic              pre_done;
    logic       [10:0] gap_reg;
    logic              moved_reg;
    logic              seen_reg;
    ubfc_baud_cfg_t    cfg_prev_reg;

    // Low speed adds a divide by four so the tick stays at 16x the bit rate
    assign pre_done = cfg_in.baud_high_speed || (pre_reg == `UBFC_LOW_PRE);

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || pre_done) begin
            pre_reg <= 2'h0;
        end else begin
            pre_reg <= 2'(pre_reg + 2'h1);
        end
    end

    // Never stopped, so a divisor change waits for the next reload
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            cnt_reg <= `UBFC_DIV_RST;
        end else if (pre_done) begin
            cnt_reg <= (cnt_reg == 8'h00) ? cfg_in.baud_divisor : 8'(cnt_reg - 8'h01);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= pre_done && (cnt_reg == 8'h00);
        end
    end

    // Period checker: cycles between ticks with a steady setting
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            gap_reg      <= 11'h000;
            moved_reg    <= 1'b1;
            seen_reg     <= 1'b0;
            cfg_prev_reg <= '0;
        end else begin
            cfg_prev_reg <= cfg_in;
            gap_reg      <= tick_out ? 11'h001 : 11'(gap_reg + 11'h001);
            moved_reg    <= tick_out ? (cfg_in != cfg_prev_reg)
                                     : (moved_reg || (cfg_in != cfg_prev_reg));
            seen_reg     <= seen_reg || tick_out;
        end
    end

    baud_period_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (tick_out && seen_reg && !moved_reg && (cfg_in == cfg_prev_reg)) |->
        (gap_reg == 11'((11'(cfg_in.baud_divisor) + 11'h001)
                        * (cfg_in.baud_high_speed ? 11'h001 : 11'h004))))
        else $error("baud tick period does not match divisor");
endmodule

// file: testbench/ubfc_remote_model.sv
// Remote serial transceiver model that faces the UART pins
`timescale 1ns/1ps
module ubfc_remote_model (
    input  wire logic ref_clk_in,
    input  wire logic tx_in,
    output logic      rx_out
);
    // Line idles high, as a pulled-up serial line does
    initial rx_out = 1'b1;
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    // Sends start, nb bits LSB first and one stop bit
    task automatic send_word(input logic [8:0] w, input int nb, input int bt);
        rx_out <= 1'b0;
        wait_cyc(bt);
        for (int i = 0; i < nb; i++) begin
            rx_out <= w[i];
            wait_cyc(bt);
        end
        rx_out <= 1'b1;
        wait_cyc(bt);
    endtask
    // Samples mid bit; bit 9 flags a low stop bit, since a stop must be high
    task automatic recv_word(input int nb, input int bt, output logic [9:0] w);
        w = '0;
        while (tx_in !== 1'b0) @(posedge ref_clk_in);
        wait_cyc(bt / 2);
        for (int i = 0; i < nb; i++) begin
            wait_cyc(bt);
            w[i] = tx_in;
        end
        wait_cyc(bt);
        w[9] = ~tx_in;
    endtask
endmodule

// file: testbench/uart_baud_and_frame_control_tb_top.sv
// Self-checking bench for the UART baud and frame control block
`timescale 1ns/1ps
`include "ubfc_params.svh"
module uart_baud_and_frame_control_tb_top;
    logic        clk, rst, hsel, hwrite, ready, rdy, hresp, rx, tx, tx_oe;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [9:0]  fr;
    int          err_count, compares;
    ubfc_top dut (.ref_clk_in(clk), .sys_rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(rdy), .hrdata_out(hrdata), .hreadyout_out(rdy), .hresp_out(hresp),
        .rx_in(rx), .tx_out(tx), .tx_oe_out(tx_oe));
    ubfc_remote_model partner (.ref_clk_in(clk), .tx_in(tx), .rx_out(rx));
    // Clock of 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One AHB single transfer; read data taken at the edge that ends the data phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
        do @(posedge clk); while (rdy !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic test_reset;
        rdchk(`UBFC_OFS_CTRL1, 32'h00);
        rdchk(`UBFC_OFS_STATUS, 32'h07);
        rdchk(8'h20, 32'h00);
        chk({tx, tx_oe}, 2'b10);
        $display("test reset done");
    endtask
    // Sends one word with a given format and speed, checks the wire bits
    task automatic test_tx(input logic [7:0] c1, input logic hs, input logic [7:0] n,
                           input logic [7:0] d, input logic [9:0] e);
        ahb(1'b1, `UBFC_OFS_CTRL1, {24'h0, c1});
        ahb(1'b1, `UBFC_OFS_CTRL2, {24'h0, 2'h3, hs, 5'h0});
        ahb(1'b1, `UBFC_OFS_DIV, {24'h0, n});
        chk(tx_oe, 1'b1);
        fork
            partner.recv_word(8, (hs ? 16 : 64) * (n + 1), fr);
            ahb(1'b1, `UBFC_OFS_DATA, {24'h0, d});
        join
        chk(fr, e);
        $display("test tx %h done", d);
    endtask
    task automatic test_rx;
        partner.send_word(9'h05a, 8, 32);
        partner.wait_cyc(40);
        rdchk(`UBFC_OFS_STATUS, 32'h8f);
        rdchk(`UBFC_OFS_DATA, 32'h5a);
        // Address detect: a word with a low top bit must vanish, a high one is kept
        ahb(1'b1, `UBFC_OFS_CTRL1, 32'h80);
        ahb(1'b1, `UBFC_OFS_CTRL2, 32'hf0);
        partner.send_word(9'h025, 8, 32);
        partner.wait_cyc(40);
        rdchk(`UBFC_OFS_STATUS, 32'h07);
        partner.send_word(9'h0a5, 8, 32);
        partner.wait_cyc(40);
        rdchk(`UBFC_OFS_STATUS, 32'h0f);
        rdchk(`UBFC_OFS_DATA, 32'ha5);
        $display("test rx done");
    endtask
    // Aborts a frame by disabling, then re-enables
    task automatic test_disable;
        ahb(1'b1, `UBFC_OFS_CTRL1, 32'hb8);
        ahb(1'b1, `UBFC_OFS_DIV, 32'h03);
        ahb(1'b1, `UBFC_OFS_DATA, 32'h00);
        partner.wait_cyc(300);
        chk(tx, 1'b0);
        ahb(1'b1, `UBFC_OFS_CTRL1, 32'h38);
        // Pins and line follow one cycle after the enable register falls
        partner.wait_cyc(2);
        chk({tx, tx_oe}, 2'b10);
        rdchk(`UBFC_OFS_STATUS, 32'h07);
        rdchk(`UBFC_OFS_CTRL2, 32'h30);
        rdchk(`UBFC_OFS_CTRL1, 32'h38);
        rdchk(`UBFC_OFS_DIV, 32'h03);
        ahb(1'b1, `UBFC_OFS_CTRL1, 32'hb8);
        rdchk(`UBFC_OFS_CTRL1, 32'hb8);
        $display("test disable done");
    endtask
    task automatic give_verdict;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog sized well above the expected run of about 3400 cycles
    initial begin
        #400000;
        err_count++;
        give_verdict();
    end
    // Main sequence
    initial begin
        rst = 1'b1; hsel = 1'b0; htrans = 2'h0; haddr = '0; hwrite = 1'b0; hwdata = '0;
        err_count = 0; compares = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_tx(8'h80, 1'b1, 8'h00, 8'h55, 10'h055);
        test_tx(8'h80, 1'b0, 8'h01, 8'ha3, 10'h0a3);
        test_tx(8'ha0, 1'b1, 8'h00, 8'h83, 10'h003);
        test_tx(8'hb0, 1'b1, 8'h01, 8'h03, 10'h083);
        test_rx();
        test_disable();
        give_verdict();
    end
endmodule
